// [core/adc_mode_alarm_map.vh]
`ifndef ADC_MODE_ALARM_MAP_VH
`define ADC_MODE_ALARM_MAP_VH
// register addresses (word index on the plain port)
`define ADDR_LINK_EN 4'h0
`define ADDR_MODE 4'h1
`define ADDR_KM1 4'h2
`define ADDR_INMUX 4'h3
`define ADDR_PWR 4'h4
`define ADDR_ALMCTL 4'h5
`define ADDR_ALMSTAT 4'h6
`define ADDR_LANEALM 4'h7
`define ADDR_ALMMASK 4'h8
`define ADDR_DERIVED 4'h9
`define ADDR_ALARM 4'hA
// field positions
`define ALM_CLK 0
`define ALM_FIFO 1
`define PWR_A 0
`define PWR_B 1
`define PWR_GLOBAL 2
`define CTL_REINIT 0
`define CTL_PINSEL 1
`define MUX_DUALSWAP 0
`define MUX_SEL_LO 1
`define MUX_SEL_HI 2
// single-input select codes
`define SEL_INA 2'h0
`define SEL_INB 2'h1
`define SEL_BOTH 2'h2
// mode codes
`define MODE_S8_8 6'h05
`define MODE_S8_16 6'h06
`define MODE_D8_8 6'h07
`define MODE_D8_16 6'h08
`define MODE_S64_4 6'h22
`define MODE_D64_4 6'h23
// R in eighths of a bit per clock
`define R_2P5 6'h14
`define R_1P25 6'h0A
`define R_4P125 6'h21
// lane counts per link, fixed E and links values
`define L_4 4'h4
`define L_8 4'h8
`define L_2 4'h2
`define E_FIXED 1'h1
`define LINKS_FIXED 2'h2
// reset values, lane count and reinit pulse length
`define KM1_RESET 8'h1F
`define MODE_RESET 6'h00
`define NLANES 16
`define REINIT_CYCLES 4'h7
`endif

// [core/adc_mode_alarm.v]
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "adc_mode_alarm_map.vh"
module adc_mode_alarm (
    input wire clk_sys,
    input wire rstn,
    input wire [3:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    input wire halfRateTick,
    input wire chanAClkPhase,
    input wire chanBClkPhase,
    input wire global_powerdown_pin,
    input wire [15:0] laneFifoFault,
    output wire linkReset,
    output wire serializerPowerdown,
    output wire serializerClkGate,
    output reg linkReinit,
    output reg [1:0] coreInterleave,
    output reg coreAInput,
    output reg coreBInput,
    output reg coreAPowerdown,
    output reg coreBPowerdown,
    output reg [5:0] laneRate,
    output reg [3:0] lanesPerLink,
    output reg [8:0] framesPerMultiframe,
    output reg multiblocksPerExt,
    output reg ilasEnable,
    output reg modeValid,
    output reg alarmSummary,
    output reg status_output_pin
);
    // software and internal state
    reg link_enable; // link on
    reg [5:0] link_mode_code; // operating mode code
    reg [7:0] frames_per_multiframe_m1; // K minus one
    reg dualSwap; // dual mode input swap
    reg [1:0] singleSel; // single mode input select
    reg chan_a_powerdown; // channel A off
    reg chan_b_powerdown; // channel B off
    reg globalPdReg; // global powerdown by register
    reg reinit_on_fifo_alarm; // auto reinit enable
    reg pinSelAlarm; // pin shows alarm summary
    reg [1:0] alarm_status_bits; // sticky alarms
    reg [15:0] fifo_alarm_per_lane; // sticky lane flags
    reg [1:0] alarmMask; // one masks the alarm
    reg globalPdPrev; // powerdown state last cycle
    reg [3:0] reinitCount; // reinit pulse length
    // derived mode values
    reg desMode; // interleave parameter
    reg enc8b10b; // encoding is 8b/10b
    reg [5:0] rDerived; // R in eighths
    reg [3:0] lDerived; // lanes per link
    reg known; // legal mode code
    wire globalPd;
    wire clkMismatch;
    wire anyLaneFault;
    wire pdExit;
    wire wrAlm;
    wire wrLane;
    wire [1:0] alarmEvents; // clock and fifo events this cycle
    wire [1:0] next_alarm; // alarm bits after this edge
    wire [15:0] alarmUpdate; // full-width sticky result

    // write strobe decode helper
    function isWrite;
        input [3:0] addr;
        input [3:0] target;
        input wr;
        begin
            isWrite = wr && (addr == target);
        end
    endfunction

    // sticky flag update: set beats clear
    function [15:0] sticky;
        input [15:0] cur;
        input [15:0] setv;
        input [15:0] clr;
        begin
            sticky = (cur & ~clr) | setv;
        end
    endfunction

    // register bit and pin both power the device down
    assign globalPd = globalPdReg | global_powerdown_pin;
    // compare only on half-rate ticks, only with link up
    assign clkMismatch = halfRateTick && link_enable && !globalPd &&
        (chanAClkPhase != chanBClkPhase);
    // one faulty lane is enough for the summary bit
    assign anyLaneFault = |laneFifoFault;
    // falling edge of the combined powerdown
    assign pdExit = globalPdPrev && !globalPd;
    // write-one-to-clear strobes for the two status words
    assign wrAlm = isWrite(regAddr, `ADDR_ALMSTAT, regWr);
    assign wrLane = isWrite(regAddr, `ADDR_LANEALM, regWr);
    // bit one fifo summary, bit zero clock upset
    assign alarmEvents = {anyLaneFault, clkMismatch | pdExit};
    // status bits: events set, host write of one clears
    assign alarmUpdate = sticky({14'h0000, alarm_status_bits},
        {14'h0000, alarmEvents},
        wrAlm ? {14'h0000, regWdata[1:0]} : 16'h0000);
    // only the two low bits carry alarms
    assign next_alarm = alarmUpdate[1:0];

    // link disabled holds block in reset, gated and off
    assign linkReset = !link_enable || linkReinit;
    assign serializerPowerdown = !link_enable;
    assign serializerClkGate = !link_enable;

    // register writes
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // all software fields to their reset values
            link_enable <= 1'b0;
            link_mode_code <= `MODE_RESET;
            frames_per_multiframe_m1 <= `KM1_RESET;
            dualSwap <= 1'b0;
            singleSel <= `SEL_INA;
            chan_a_powerdown <= 1'b0;
            chan_b_powerdown <= 1'b0;
            globalPdReg <= 1'b0;
            reinit_on_fifo_alarm <= 1'b0;
            pinSelAlarm <= 1'b0;
            alarmMask <= 2'h0;
        end else if (regWr) begin
            case (regAddr)
                `ADDR_LINK_EN: begin
                    // link on or off, no side conditions
                    link_enable <= regWdata[0];
                end
                `ADDR_MODE: begin
                    // parameters change only with link off
                    if (!link_enable) begin
                        link_mode_code <= regWdata[5:0];
                    end
                end
                `ADDR_KM1: begin
                    // K minus one, frozen while link runs
                    if (!link_enable) begin
                        frames_per_multiframe_m1 <= regWdata[7:0];
                    end
                end
                `ADDR_INMUX: begin
                    // input routing, takes effect next edge
                    dualSwap <= regWdata[`MUX_DUALSWAP];
                    singleSel <= regWdata[`MUX_SEL_HI:`MUX_SEL_LO];
                end
                `ADDR_PWR: begin
                    // per-channel and global powerdown
                    chan_a_powerdown <= regWdata[`PWR_A];
                    chan_b_powerdown <= regWdata[`PWR_B];
                    globalPdReg <= regWdata[`PWR_GLOBAL];
                end
                `ADDR_ALMCTL: begin
                    // auto reinit and pin source
                    reinit_on_fifo_alarm <= regWdata[`CTL_REINIT];
                    pinSelAlarm <= regWdata[`CTL_PINSEL];
                end
                `ADDR_ALMMASK: begin
                    // one bit per alarm, one masks it
                    alarmMask <= regWdata[1:0];
                end
                default: begin
                    // other addresses: status words clear by strobe, the rest hold no writable state
                end
            endcase
        end
    end

    // sticky alarms, lane flags, powerdown history
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alarm_status_bits <= 2'h0;
            fifo_alarm_per_lane <= 16'h0000;
            globalPdPrev <= 1'b0;
        end else begin
            alarm_status_bits <= next_alarm;
            // lane flags: fault sets, write of one clears
            fifo_alarm_per_lane <= sticky(fifo_alarm_per_lane,
                laneFifoFault,
                wrLane ? regWdata[15:0] : 16'h0000);
            // remembered for powerdown exit detect
            globalPdPrev <= globalPd;
        end
    end

    // automatic reinit pulse on fifo fault
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reinitCount <= 4'h0;
            linkReinit <= 1'b0;
        end else if (anyLaneFault && reinit_on_fifo_alarm && link_enable) begin
            // fault with reinit enabled: restart the pulse
            reinitCount <= `REINIT_CYCLES;
            linkReinit <= 1'b1;
        end else if (reinitCount != 4'h0) begin
            // count down, drop on the last count
            reinitCount <= reinitCount - 4'h1;
            linkReinit <= (reinitCount != 4'h1);
        end else begin
            linkReinit <= 1'b0;
        end
    end

    // mode code decode into transport parameters
    always @* begin
        // defaults: dual channel, 8b/10b, four lanes per link
        desMode = 1'b0;
        enc8b10b = 1'b1;
        rDerived = `R_2P5;
        lDerived = `L_4;
        known = 1'b1;
        case (link_mode_code)
            `MODE_S8_8: begin
                // single channel, eight lanes
                desMode = 1'b1;
            end
            `MODE_S8_16: begin
                // single channel, sixteen lanes
                desMode = 1'b1;
                rDerived = `R_1P25;
                lDerived = `L_8;
            end
            `MODE_D8_8: begin
                // dual channel, eight lanes
                desMode = 1'b0;
            end
            `MODE_D8_16: begin
                // dual channel, sixteen lanes
                rDerived = `R_1P25;
                lDerived = `L_8;
            end
            `MODE_S64_4: begin
                // single channel, 64b/66b, four lanes
                desMode = 1'b1;
                enc8b10b = 1'b0;
                rDerived = `R_4P125;
                lDerived = `L_2;
            end
            `MODE_D64_4: begin
                // dual channel, 64b/66b, four lanes
                enc8b10b = 1'b0;
                rDerived = `R_4P125;
                lDerived = `L_2;
            end
            default: begin
                // reserved code
                known = 1'b0;
            end
        endcase
    end

    // registered parameters and core routing
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            coreInterleave <= 2'h0;
            coreAInput <= 1'b0;
            coreBInput <= 1'b1;
            coreAPowerdown <= 1'b1;
            coreBPowerdown <= 1'b1;
            laneRate <= 6'h00;
            lanesPerLink <= 4'h0;
            framesPerMultiframe <= 9'h000;
            multiblocksPerExt <= 1'b0;
            ilasEnable <= 1'b0;
            modeValid <= 1'b0;
        end else begin
            // transport parameters follow the decode
            modeValid <= known;
            laneRate <= rDerived;
            lanesPerLink <= lDerived;
            // K used only with 8b/10b
            framesPerMultiframe <= enc8b10b ?
                {1'b0, frames_per_multiframe_m1} + 9'h001 : 9'h000;
            // E used only with 64b/66b
            multiblocksPerExt <= enc8b10b ? 1'b0 : `E_FIXED;
            ilasEnable <= enc8b10b && link_enable;
            if (desMode) begin
                // both cores on one stream, output as single
                coreAPowerdown <= globalPd;
                coreBPowerdown <= globalPd;
                // both inputs: cores sample out of phase
                if (singleSel == `SEL_BOTH) begin
                    coreInterleave <= 2'h2;
                    coreAInput <= 1'b0;
                    coreBInput <= 1'b1;
                end else begin
                    coreInterleave <= 2'h1;
                    coreAInput <= (singleSel == `SEL_INB);
                    coreBInput <= (singleSel == `SEL_INB);
                end
            end else begin
                // dual: one input per core, own powerdowns
                coreInterleave <= 2'h0;
                coreAInput <= dualSwap;
                coreBInput <= !dualSwap;
                coreAPowerdown <= globalPd || chan_a_powerdown;
                coreBPowerdown <= globalPd || chan_b_powerdown;
            end
        end
    end

    // summary alarm and status pin
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alarmSummary <= 1'b0;
            status_output_pin <= 1'b0;
        end else begin
            // unmasked alarms, same edge as the status bit
            alarmSummary <= |(next_alarm & ~alarmMask);
            // pin repeats the summary when selected
            status_output_pin <= pinSelAlarm &&
                (|(next_alarm & ~alarmMask));
        end
    end

    // read port, data one cycle after strobe
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                // control fields
                `ADDR_LINK_EN: regRdata <= {31'h0, link_enable};
                `ADDR_MODE: regRdata <= {26'h0, link_mode_code};
                `ADDR_KM1: regRdata <= {24'h0, frames_per_multiframe_m1};
                `ADDR_INMUX: regRdata <= {29'h0, singleSel, dualSwap};
                `ADDR_PWR: regRdata <= {29'h0, globalPdReg,
                    chan_b_powerdown, chan_a_powerdown};
                `ADDR_ALMCTL: regRdata <= {30'h0, pinSelAlarm,
                    reinit_on_fifo_alarm};
                // status, mask and derived words
                `ADDR_ALMSTAT: regRdata <= {30'h0, alarm_status_bits};
                `ADDR_LANEALM: regRdata <= {16'h0, fifo_alarm_per_lane};
                `ADDR_ALMMASK: regRdata <= {30'h0, alarmMask};
                `ADDR_DERIVED: regRdata <= {14'h0, modeValid,
                    multiblocksPerExt, lanesPerLink, laneRate,
                    `LINKS_FIXED, coreInterleave, enc8b10b, desMode};
                `ADDR_ALARM: regRdata <= {31'h0, alarmSummary};
                // unmapped indexes read as zero
                default: regRdata <= 32'h00000000;
            endcase
        end else begin
            // zero outside the read cycle
            regRdata <= 32'h00000000;
        end
    end
endmodule // adc_mode_alarm

// [verification/adc_mode_alarm_props.sv]
`timescale 1ns/1ps
`include "adc_mode_alarm_map.vh"
module adc_mode_alarm_props (
    input logic clk_sys,
    input logic rstn,
    input logic [3:0] regAddr,
    input logic [31:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdata,
    input logic halfRateTick,
    input logic chanAClkPhase,
    input logic chanBClkPhase,
    input logic global_powerdown_pin,
    input logic [15:0] laneFifoFault,
    input logic linkReset,
    input logic serializerPowerdown,
    input logic serializerClkGate,
    input logic linkReinit,
    input logic [1:0] coreInterleave,
    input logic coreAInput,
    input logic coreBInput,
    input logic [8:0] framesPerMultiframe,
    input logic multiblocksPerExt,
    input logic ilasEnable,
    input logic status_output_pin
);
    logic pdReg; // shadow of the global powerdown register bit
    logic upsetSeen; // clock mismatch seen since last clear
    logic fifoSeen; // lane fault seen since last clear
    logic [15:0] laneSeen; // per-lane faults since last clear
    wire phaseDiff = halfRateTick && (chanAClkPhase != chanBClkPhase);
    wire upsetCause = phaseDiff && !serializerPowerdown
        && !global_powerdown_pin && !pdReg; // compare only when live
    wire clrAlm = regWr && regAddr == `ADDR_ALMSTAT;
    wire clrLane = regWr && regAddr == `ADDR_LANEALM;
    // track powerdown writes and the alarms the host must see
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pdReg <= 1'b0;
            upsetSeen <= 1'b0;
            fifoSeen <= 1'b0;
            laneSeen <= 16'h0000;
        end else begin
            if (regWr && regAddr == `ADDR_PWR) begin
                pdReg <= regWdata[`PWR_GLOBAL];
            end
            // an event in the clearing cycle keeps the flag
            upsetSeen <= upsetCause
                || (upsetSeen && !(clrAlm && regWdata[`ALM_CLK]));
            fifoSeen <= (|laneFifoFault)
                || (fifoSeen && !(clrAlm && regWdata[`ALM_FIFO]));
            laneSeen <= laneFifoFault
                | (laneSeen & ~(clrLane ? regWdata[15:0] : 16'h0000));
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_linkoff;
        serializerPowerdown |-> linkReset && serializerClkGate;
    endproperty
    a_linkoff: assert property (p_linkoff)
        else $error("link off without reset and gating");
    property p_reinit;
        $rose(linkReinit) |-> linkReinit[*7];
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("reinit pulse shorter than seven cycles");
    property p_linkwr;
        regWr && regAddr == `ADDR_LINK_EN
            |=> serializerPowerdown == !$past(regWdata[0]);
    endproperty
    a_linkwr: assert property (p_linkwr)
        else $error("link enable write not applied");
    property p_upset;
        $past(upsetSeen) && $past(regRd)
            && $past(regAddr) == `ADDR_ALMSTAT |-> regRdata[`ALM_CLK];
    endproperty
    a_upset: assert property (p_upset)
        else $error("clock mismatch not flagged");
    property p_fifo;
        $past(fifoSeen) && $past(regRd)
            && $past(regAddr) == `ADDR_ALMSTAT |-> regRdata[`ALM_FIFO];
    endproperty
    a_fifo: assert property (p_fifo)
        else $error("lane fault not in summary");
    property p_lanes;
        $past(regRd) && $past(regAddr) == `ADDR_LANEALM
            |-> (regRdata[15:0] & $past(laneSeen)) == $past(laneSeen);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane flag missing");
    property p_rdidle;
        !$past(regRd) |-> regRdata == 32'h0;
    endproperty
    a_rdidle: assert property (p_rdidle)
        else $error("read data outside read cycle");
    property p_enc64;
        multiblocksPerExt |-> framesPerMultiframe == 9'h000 && !ilasEnable;
    endproperty
    a_enc64: assert property (p_enc64)
        else $error("64b66b mode with 8b10b parameters");
    property p_dualroute;
        coreInterleave == 2'h0 |-> coreAInput != coreBInput;
    endproperty
    a_dualroute: assert property (p_dualroute)
        else $error("dual mode cores share one input");
    c_reinit: cover property ($rose(linkReinit));
    c_dualin: cover property (coreInterleave == 2'h2);
    c_pin: cover property (status_output_pin);
endmodule // adc_mode_alarm_props
bind adc_mode_alarm adc_mode_alarm_props adc_mode_alarm_props_i (
    .clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .halfRateTick, .chanAClkPhase, .chanBClkPhase, .global_powerdown_pin,
    .laneFifoFault, .linkReset, .serializerPowerdown, .serializerClkGate,
    .linkReinit, .coreInterleave, .coreAInput, .coreBInput,
    .framesPerMultiframe, .multiblocksPerExt, .ilasEnable,
    .status_output_pin);

// [verification/testbench.sv]
`timescale 1ns/1ps
`include "adc_mode_alarm_map.vh"
module testbench;
    logic clk_sys = 1'b0; // 20 MHz system clock
    logic rstn = 1'b0; // reset, active low
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic halfRateTick = 1'b0;
    logic chanAClkPhase = 1'b0;
    logic chanBClkPhase = 1'b0;
    logic global_powerdown_pin = 1'b0;
    logic [15:0] laneFifoFault = 16'h0;
    wire [31:0] regRdata;
    wire linkReset, serializerPowerdown, serializerClkGate, linkReinit;
    wire [1:0] coreInterleave;
    wire coreAInput, coreBInput, coreAPowerdown, coreBPowerdown;
    wire [5:0] laneRate;
    wire [3:0] lanesPerLink;
    wire [8:0] framesPerMultiframe;
    wire multiblocksPerExt, ilasEnable, modeValid;
    wire alarmSummary, status_output_pin;
    int err_total = 0; // mismatches
    int num_checks = 0; // comparisons made
    int cycles = 0; // run length guard
    int n; // reinit length count
    // mode codes and their derived register words
    logic [5:0] md [6] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h22, 6'h23};
    logic [31:0] dv [6] = '{32'h00024527, 32'h000282A7, 32'h00024522,
        32'h000282A2, 32'h00032865, 32'h00032860};
    adc_mode_alarm adc_mode_alarm_i (.clk_sys, .rstn, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .halfRateTick, .chanAClkPhase,
        .chanBClkPhase, .global_powerdown_pin, .laneFifoFault, .linkReset,
        .serializerPowerdown, .serializerClkGate, .linkReinit,
        .coreInterleave, .coreAInput, .coreBInput, .coreAPowerdown,
        .coreBPowerdown, .laneRate, .lanesPerLink, .framesPerMultiframe,
        .multiblocksPerExt, .ilasEnable, .modeValid, .alarmSummary,
        .status_output_pin);
    always #25 clk_sys = ~clk_sys;
    // half-rate compare marks
    always @(posedge clk_sys) halfRateTick <= ~halfRateTick;
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            close_out;
        end
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(nm, regRdata, exp);
    endtask
    task step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd("km1", `ADDR_KM1, 32'h1F);
        rd("mode", `ADDR_MODE, 32'h0);
        rd("unmapped", 4'hF, 32'h0);
        chk("off", {29'h0, linkReset, serializerPowerdown,
            serializerClkGate}, 32'h7);
        // every mode code with its derived parameters
        for (int i = 0; i < 6; i++) begin
            wr(`ADDR_MODE, {26'h0, md[i]});
            rd("derived", `ADDR_DERIVED, dv[i]);
            chk("kframes", {23'h0, framesPerMultiframe},
                i < 4 ? 32'h20 : 32'h0);
        end
        wr(`ADDR_MODE, 32'h7);
        step(1);
        chk("dual", {28'h0, coreInterleave, coreAInput,
            coreBInput}, 32'h1);
        wr(`ADDR_INMUX, 32'h1);
        step(1);
        chk("swap", {28'h0, coreInterleave, coreAInput,
            coreBInput}, 32'h2);
        wr(`ADDR_PWR, 32'h1);
        step(1);
        chk("pdA", {30'h0, coreAPowerdown, coreBPowerdown}, 32'h2);
        wr(`ADDR_PWR, 32'h0);
        wr(`ADDR_MODE, 32'h5);
        wr(`ADDR_INMUX, 32'h2);
        step(1);
        chk("selB", {28'h0, coreInterleave, coreAInput,
            coreBInput}, 32'h7);
        wr(`ADDR_INMUX, 32'h4);
        step(1);
        chk("both", {28'h0, coreInterleave, coreAInput,
            coreBInput}, 32'h9);
        rd("bothder", `ADDR_DERIVED, 32'h0002452B);
        wr(`ADDR_INMUX, 32'h0);
        wr(`ADDR_LINK_EN, 32'h1);
        step(1);
        chk("on", {28'h0, linkReset, serializerPowerdown,
            serializerClkGate, ilasEnable}, 32'h1);
        wr(`ADDR_MODE, 32'h7);
        rd("locked", `ADDR_MODE, 32'h5);
        // clock upset: clear, glitch, sticky, clear
        wr(`ADDR_ALMSTAT, 32'h1);
        rd("upclr", `ADDR_ALMSTAT, 32'h0);
        @(posedge clk_sys);
        chanBClkPhase <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chanBClkPhase <= 1'b0;
        rd("upset", `ADDR_ALMSTAT, 32'h1);
        step(5);
        rd("sticky", `ADDR_ALMSTAT, 32'h1);
        wr(`ADDR_ALMSTAT, 32'h1);
        rd("w1c", `ADDR_ALMSTAT, 32'h0);
        // powerdown exit by pin
        @(posedge clk_sys);
        global_powerdown_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        global_powerdown_pin <= 1'b0;
        step(2);
        rd("pdexit", `ADDR_ALMSTAT, 32'h1);
        wr(`ADDR_ALMSTAT, 32'h1);
        // lane fault with reinit and pin enabled
        wr(`ADDR_ALMCTL, 32'h3);
        @(posedge clk_sys);
        laneFifoFault <= 16'h0008;
        @(posedge clk_sys);
        laneFifoFault <= 16'h0000;
        n = 0;
        repeat (12) begin
            #1 if (linkReinit === 1'b1) n++;
            @(posedge clk_sys);
        end
        chk("reinit", n, 32'h7);
        #1 chk("pin", {30'h0, alarmSummary, status_output_pin}, 32'h3);
        rd("fifo", `ADDR_ALMSTAT, 32'h2);
        rd("lanes", `ADDR_LANEALM, 32'h8);
        rd("summary", `ADDR_ALARM, 32'h1);
        wr(`ADDR_ALMMASK, 32'h2);
        step(1);
        chk("masked", {31'h0, alarmSummary}, 32'h0);
        wr(`ADDR_ALMSTAT, 32'h2);
        wr(`ADDR_LANEALM, 32'h8);
        rd("fifoclr", `ADDR_ALMSTAT, 32'h0);
        rd("laneclr", `ADDR_LANEALM, 32'h0);
        close_out;
    end
endmodule // testbench
